// ==== sdm_pkg.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Shared constants
package sdm_pkg;
	localparam int          NUM_BANKS      = 8;
	localparam int          PREFETCH_WORDS = 8;
	localparam int          CORE_CLOCKS    = 4;
	localparam int          ADDR_W         = 15;
	localparam int          BANK_W         = 3;
	localparam int          MODE_REGS      = 4;
	// Mode register zero fields
	localparam int          MR0_BL_LSB     = 0;
	localparam int          MR0_BT_BIT     = 3;
	localparam int          MR0_DLLRST_BIT = 8;
	localparam logic [1:0]  BL_FIXED_EIGHT = 2'h0;
	localparam logic [1:0]  BL_ON_THE_FLY  = 2'h1;
	localparam logic [1:0]  BL_FIXED_FOUR  = 2'h2;
	// Command address bits
	localparam int          AUTO_PRE_BIT   = 10;
	localparam int          CHOP_SEL_BIT   = 12;
	// Burst slots and fixed-four write start pull-in
	localparam logic [7:0]  SLOTS_FOUR     = 8'h0f;
	localparam logic [7:0]  SLOTS_EIGHT    = 8'hff;
	localparam logic [3:0]  FOUR_PULL_IN   = 4'h2;
	// Register map
	localparam logic [7:0]  OFS_MODE0      = 8'h00;
	localparam logic [7:0]  OFS_MODE1      = 8'h04;
	localparam logic [7:0]  OFS_MODE2      = 8'h08;
	localparam logic [7:0]  OFS_MODE3      = 8'h0c;
	localparam logic [7:0]  OFS_STATUS     = 8'h10;
	localparam logic [7:0]  OFS_CTRL       = 8'h14;
	// Status fields, control reset value, bus transfer type
	localparam int          ST_STATE_LSB   = 0;
	localparam int          ST_BUSY_BIT    = 2;
	localparam int          ST_TERM_BIT    = 3;
	localparam int          ST_WRITTEN_LSB = 4;
	localparam int          ST_BANKS_LSB   = 8;
	localparam logic [3:0]  CTRL_WBASE_RST = 4'h5;
	localparam logic [1:0]  HTRANS_NONSEQ  = 2'h2;

	typedef enum logic [1:0] {
		SDM_IN_RESET,
		SDM_WAIT_CKE,
		SDM_READY
	} sdm_init_t;

	typedef enum logic [2:0] {
		SDM_CMD_NONE,
		SDM_CMD_MODE,
		SDM_CMD_ACT,
		SDM_CMD_RD,
		SDM_CMD_WR,
		SDM_CMD_PRE,
		SDM_CMD_OTHER
	} sdm_cmd_t;
endpackage

// ==========================================================
// Burst column order
module sdm_burst_order (
	input  wire logic [2:0]  col_in,
	input  wire logic        interleave_in,
	input  wire logic        chop_in,
	input  wire logic        write_in,
	output logic      [23:0] order_out,
	output logic      [7:0]  slot_valid_out
);
	for (genvar i = 0; i < 8; i++) begin : g_slot
		localparam logic [2:0] IDX = 3'(i);
		assign order_out[3*i +: 3] = write_in ?
			(chop_in ? {col_in[2], IDX[1:0]} : IDX) :
			(interleave_in ? (col_in ^ IDX) :
			{col_in[2] ^ IDX[2], 2'(col_in[1:0] + IDX[1:0])});
	end
	// Chopped bursts mark only the low four slots valid
	assign slot_valid_out = chop_in ? sdm_pkg::SLOTS_FOUR
		: sdm_pkg::SLOTS_EIGHT;
endmodule

`default_nettype wire

// ==== sdm_core.sv ====
// Function
// - Eight banks, 8n prefetch per access
// - Bursts of eight or chopped four
// - Column, auto-precharge, chop select at access
// - Internal init while waiting for clock-enable
// - Termination high impedance until clock-enable registered
// - Mode writes leave array untouched
// - Burst type and length fields decoded
// - Read burst order from low column bits; writes run slots in order
// - Fixed four starts internal write earlier
// - Delay-loop reset bit clears itself
//
// Implementation choices: the register addresses and register access over AHB-Lite.
`timescale 1ns/1ps
`default_nettype none

module sdm_core #(
	parameter logic [3:0] WBASE_RESET = sdm_pkg::CTRL_WBASE_RST
) (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	// Memory pins
	input  wire logic        dev_resetn_in,
	input  wire logic        cke_in,
	input  wire logic        cs_n_in,
	input  wire logic        ras_n_in,
	input  wire logic        cas_n_in,
	input  wire logic        we_n_in,
	input  wire logic [2:0]  bank_select_lines_in,
	input  wire logic [14:0] addr_in,
	input  wire logic        termination_control_input_in,
	// Internal outputs
	output logic             termination_enable_out,
	output logic             init_busy_out,
	output logic             dll_reset_out,
	output logic             burst_start_out,
	output logic             burst_write_out,
	output logic             burst_chop_out,
	output logic             auto_precharge_out,
	output logic      [2:0]  burst_bank_out,
	output logic      [14:0] burst_col_out,
	output logic      [23:0] burst_order_out,
	output logic      [7:0]  burst_slot_valid_out,
	output logic      [3:0]  write_start_delay_out,
	// AHB-Lite slave
	input  wire logic        hsel_in,
	input  wire logic [31:0] haddr_in,
	input  wire logic [1:0]  htrans_in,
	input  wire logic        hwrite_in,
	input  wire logic [2:0]  hsize_in,
	input  wire logic [31:0] hwdata_in,
	input  wire logic        hready_in,
	output logic      [31:0] hrdata_out,
	output logic             hreadyout_out,
	output logic             hresp_out
);
	// ======================================================
	// Command decode
	function automatic sdm_pkg::sdm_cmd_t decode(input logic cs_n,
		input logic ras_n, input logic cas_n, input logic we_n);
		logic [2:0] c;
		c = {ras_n, cas_n, we_n};
		if (cs_n)
			return sdm_pkg::SDM_CMD_NONE;
		else if (c == 3'h0)
			return sdm_pkg::SDM_CMD_MODE;
		else if (c == 3'h3)
			return sdm_pkg::SDM_CMD_ACT;
		else if (c == 3'h5)
			return sdm_pkg::SDM_CMD_RD;
		else if (c == 3'h4)
			return sdm_pkg::SDM_CMD_WR;
		else if (c == 3'h2)
			return sdm_pkg::SDM_CMD_PRE;
		else if (c == 3'h7)
			return sdm_pkg::SDM_CMD_NONE;
		else
			return sdm_pkg::SDM_CMD_OTHER;
	endfunction

	sdm_pkg::sdm_init_t state_reg, state_next;
	sdm_pkg::sdm_cmd_t  cmd_now;
	logic [14:0] mode_reg [sdm_pkg::MODE_REGS];
	logic [14:0] mode_next [sdm_pkg::MODE_REGS];
	logic [3:0]  written_reg, written_next;
	logic [7:0]  banks_reg, banks_next;
	logic        term_reg, term_next;
	logic        dll_reg, dll_next;
	logic        start_reg, start_next;
	logic        wr_reg, wr_next;
	logic        chop_reg, chop_next;
	logic        ap_reg, ap_next;
	logic [2:0]  bank_reg, bank_next;
	logic [14:0] col_reg, col_next;
	logic [23:0] order_reg, order_next;
	logic [7:0]  slots_reg, slots_next;
	logic [3:0]  wdly_reg, wdly_next;
	logic [3:0]  wbase_reg, wbase_next;
	logic        chop_now;
	logic [1:0]  bl_mode;
	logic [23:0] order_now;
	logic [7:0]  slots_now;
	logic        access_now;

	assign cmd_now = cke_in ? decode(cs_n_in, ras_n_in, cas_n_in, we_n_in)
		: sdm_pkg::SDM_CMD_NONE;
	assign bl_mode = mode_reg[0][sdm_pkg::MR0_BL_LSB +: 2];
	assign chop_now = (bl_mode == sdm_pkg::BL_FIXED_FOUR) ||
		((bl_mode == sdm_pkg::BL_ON_THE_FLY) &&
		!addr_in[sdm_pkg::CHOP_SEL_BIT]);
	assign access_now = (state_reg == sdm_pkg::SDM_READY) &&
		((cmd_now == sdm_pkg::SDM_CMD_RD) ||
		(cmd_now == sdm_pkg::SDM_CMD_WR));

	sdm_burst_order u_order (
		.col_in         (addr_in[2:0]),
		.interleave_in  (mode_reg[0][sdm_pkg::MR0_BT_BIT]),
		.chop_in        (chop_now),
		.write_in       (cmd_now == sdm_pkg::SDM_CMD_WR),
		.order_out      (order_now),
		.slot_valid_out (slots_now)
	);

	// ======================================================
	// Device state
	always_comb begin
		state_next   = state_reg;
		mode_next    = mode_reg;
		written_next = written_reg;
		banks_next   = banks_reg;
		term_next    = 1'b0;
		dll_next     = 1'b0;
		start_next   = 1'b0;
		wr_next      = wr_reg;
		chop_next    = chop_reg;
		ap_next      = ap_reg;
		bank_next    = bank_reg;
		col_next     = col_reg;
		order_next   = order_reg;
		slots_next   = slots_reg;
		wdly_next    = wdly_reg;
		if (mode_reg[0][sdm_pkg::MR0_DLLRST_BIT])
			mode_next[0][sdm_pkg::MR0_DLLRST_BIT] = 1'b0;
		if (!dev_resetn_in) begin
			state_next   = sdm_pkg::SDM_IN_RESET;
			written_next = 4'h0;
			banks_next   = 8'h00;
		end else begin
			case (state_reg)
			sdm_pkg::SDM_IN_RESET: begin
				state_next = sdm_pkg::SDM_WAIT_CKE;
			end
			sdm_pkg::SDM_WAIT_CKE: begin
				if (cke_in)
					state_next = sdm_pkg::SDM_READY;
			end
			default: begin
				term_next = termination_control_input_in;
				case (cmd_now)
				sdm_pkg::SDM_CMD_MODE: begin
					// Array and open banks untouched
					mode_next[bank_select_lines_in[1:0]] = addr_in;
					written_next[bank_select_lines_in[1:0]] = 1'b1;
					dll_next = (bank_select_lines_in[1:0] == 2'h0) &&
						addr_in[sdm_pkg::MR0_DLLRST_BIT];
				end
				sdm_pkg::SDM_CMD_ACT: begin
					banks_next[bank_select_lines_in] = 1'b1;
				end
				sdm_pkg::SDM_CMD_PRE: begin
					if (addr_in[sdm_pkg::AUTO_PRE_BIT])
						banks_next = 8'h00;
					else
						banks_next[bank_select_lines_in] = 1'b0;
				end
				sdm_pkg::SDM_CMD_RD, sdm_pkg::SDM_CMD_WR: begin
					start_next = 1'b1;
					wr_next    = (cmd_now == sdm_pkg::SDM_CMD_WR);
					chop_next  = chop_now;
					ap_next    = addr_in[sdm_pkg::AUTO_PRE_BIT];
					bank_next  = bank_select_lines_in;
					col_next   = addr_in;
					order_next = order_now;
					slots_next = slots_now;
					if (addr_in[sdm_pkg::AUTO_PRE_BIT])
						banks_next[bank_select_lines_in] = 1'b0;
					if (bl_mode == sdm_pkg::BL_FIXED_FOUR &&
						wbase_reg >= sdm_pkg::FOUR_PULL_IN)
						wdly_next = wbase_reg - sdm_pkg::FOUR_PULL_IN;
					else
						wdly_next = wbase_reg;
				end
				default: begin
				end
				endcase
			end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			state_reg   <= sdm_pkg::SDM_IN_RESET;
			for (int i = 0; i < sdm_pkg::MODE_REGS; i++) begin
				mode_reg[i] <= 15'h0000;
			end
			written_reg <= 4'h0;
			banks_reg   <= 8'h00;
			term_reg    <= 1'b0;
			dll_reg     <= 1'b0;
			start_reg   <= 1'b0;
			wr_reg      <= 1'b0;
			chop_reg    <= 1'b0;
			ap_reg      <= 1'b0;
			bank_reg    <= 3'h0;
			col_reg     <= 15'h0000;
			order_reg   <= 24'h000000;
			slots_reg   <= 8'h00;
			wdly_reg    <= 4'h0;
		end else begin
			state_reg   <= state_next;
			mode_reg    <= mode_next;
			written_reg <= written_next;
			banks_reg   <= banks_next;
			term_reg    <= term_next;
			dll_reg     <= dll_next;
			start_reg   <= start_next;
			wr_reg      <= wr_next;
			chop_reg    <= chop_next;
			ap_reg      <= ap_next;
			bank_reg    <= bank_next;
			col_reg     <= col_next;
			order_reg   <= order_next;
			slots_reg   <= slots_next;
			wdly_reg    <= wdly_next;
		end
	end

	assign termination_enable_out = term_reg;
	assign init_busy_out          = (state_reg != sdm_pkg::SDM_READY);
	assign dll_reset_out          = dll_reg;
	assign burst_start_out        = start_reg;
	assign burst_write_out        = wr_reg;
	assign burst_chop_out         = chop_reg;
	assign auto_precharge_out     = ap_reg;
	assign burst_bank_out         = bank_reg;
	assign burst_col_out          = col_reg;
	assign burst_order_out        = order_reg;
	assign burst_slot_valid_out   = slots_reg;
	assign write_start_delay_out  = wdly_reg;

	// ======================================================
	// AHB-Lite register slave
	logic        take;
	logic        apw_reg, apw_next;
	logic [7:0]  apa_reg, apa_next;
	logic [31:0] hrdata_reg, hrdata_next;
	logic [31:0] status_word;

	assign take = hsel_in && htrans_in[1] && hready_in;
	always_comb begin
		status_word = 32'h00000000;
		status_word[sdm_pkg::ST_STATE_LSB +: 2] = state_reg;
		status_word[sdm_pkg::ST_BUSY_BIT]        = init_busy_out;
		status_word[sdm_pkg::ST_TERM_BIT]        = term_reg;
		status_word[sdm_pkg::ST_WRITTEN_LSB +: 4] = written_reg;
		status_word[sdm_pkg::ST_BANKS_LSB +: 8]   = banks_reg;
	end

	always_comb begin
		apw_next    = take && hwrite_in && (haddr_in[31:8] == 24'h000000);
		apa_next    = take ? haddr_in[7:0] : apa_reg;
		hrdata_next = hrdata_reg;
		wbase_next  = wbase_reg;
		if (apw_reg && apa_reg == sdm_pkg::OFS_CTRL)
			wbase_next = hwdata_in[3:0];
		if (take && !hwrite_in) begin
			if (haddr_in[31:8] != 24'h000000)
				hrdata_next = 32'h00000000;
			else if (haddr_in[7:0] == sdm_pkg::OFS_MODE0)
				hrdata_next = {17'h00000, mode_reg[0]};
			else if (haddr_in[7:0] == sdm_pkg::OFS_MODE1)
				hrdata_next = {17'h00000, mode_reg[1]};
			else if (haddr_in[7:0] == sdm_pkg::OFS_MODE2)
				hrdata_next = {17'h00000, mode_reg[2]};
			else if (haddr_in[7:0] == sdm_pkg::OFS_MODE3)
				hrdata_next = {17'h00000, mode_reg[3]};
			else if (haddr_in[7:0] == sdm_pkg::OFS_STATUS)
				hrdata_next = status_word;
			else if (haddr_in[7:0] == sdm_pkg::OFS_CTRL)
				hrdata_next = {28'h0000000, wbase_reg};
			else
				hrdata_next = 32'h00000000;
		end
	end

	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			apw_reg    <= 1'b0;
			apa_reg    <= 8'h00;
			hrdata_reg <= 32'h00000000;
			wbase_reg  <= WBASE_RESET;
		end else begin
			apw_reg    <= apw_next;
			apa_reg    <= apa_next;
			hrdata_reg <= hrdata_next;
			wbase_reg  <= wbase_next;
		end
	end

	assign hrdata_out    = hrdata_reg;
	assign hreadyout_out = 1'b1;
	assign hresp_out     = 1'b0;

	// ======================================================
	// Checks
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!resetn_in);

	sequence s_dll_write;
		state_reg == sdm_pkg::SDM_READY && dev_resetn_in &&
		cmd_now == sdm_pkg::SDM_CMD_MODE &&
		bank_select_lines_in[1:0] == 2'h0 && addr_in[8];
	endsequence
	sequence s_dll_done;
		dll_reset_out && mode_reg[0][8] ##1
		!mode_reg[0][8];
	endsequence

	AST_TERM_HIZ_RESET: assert property (!dev_resetn_in |=>
		!termination_enable_out ##1 !termination_enable_out)
		else $error("termination active during reset");
	AST_TERM_HIZ_WAIT: assert property (
		state_reg != sdm_pkg::SDM_READY |=> !termination_enable_out)
		else $error("termination active before clock enable");
	AST_DLL_SELF_CLEAR: assert property (
		s_dll_write |=> s_dll_done)
		else $error("delay loop reset bit did not clear");
	AST_AUTO_PRE: assert property (access_now && dev_resetn_in |=>
		burst_start_out && auto_precharge_out == $past(addr_in[10]))
		else $error("auto precharge not captured");
	AST_FIXED_EIGHT: assert property (access_now && dev_resetn_in &&
		bl_mode == sdm_pkg::BL_FIXED_EIGHT |=> !burst_chop_out)
		else $error("fixed eight burst chopped");
	AST_FLY_CHOP: assert property (access_now && dev_resetn_in &&
		bl_mode == sdm_pkg::BL_ON_THE_FLY |=>
		burst_chop_out == !$past(addr_in[12]))
		else $error("on the fly chop wrong");
	AST_CHOP_SLOTS: assert property (burst_start_out &&
		burst_chop_out |-> burst_slot_valid_out == 8'h0f)
		else $error("chopped burst slots wrong");
	AST_WRITE_PULL_IN: assert property (access_now && dev_resetn_in &&
		bl_mode == sdm_pkg::BL_FIXED_FOUR && wbase_reg >= 4'h2 |=>
		write_start_delay_out == $past(wbase_reg) - 4'h2)
		else $error("fixed four write start not pulled in");
	AST_MODE_KEEPS_BANKS: assert property (state_reg ==
		sdm_pkg::SDM_READY && dev_resetn_in &&
		cmd_now == sdm_pkg::SDM_CMD_MODE |=> $stable(banks_reg))
		else $error("mode write changed bank state");
	AST_ACT_OPENS: assert property (state_reg == sdm_pkg::SDM_READY &&
		dev_resetn_in && cmd_now == sdm_pkg::SDM_CMD_ACT |=>
		banks_reg[$past(bank_select_lines_in)])
		else $error("activate did not open bank");
endmodule

`default_nettype wire

// ==== sdm_ctl_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Memory controller model driving the command pins
module sdm_ctl_model #(
	parameter int XPR_CYC  = 5,
	parameter int MRD_CYC  = 4,
	parameter int LOCK_CYC = 16
) (
	input  wire logic        clk_in,
	output logic             dev_resetn_out,
	output logic             cke_out,
	output logic             cs_n_out,
	output logic             ras_n_out,
	output logic             cas_n_out,
	output logic             we_n_out,
	output logic      [2:0]  bank_out,
	output logic      [14:0] addr_out,
	output logic             term_out
);
	initial begin
		dev_resetn_out = 1'b0;
		cke_out = 1'b0;
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} = 4'hf;
		bank_out = 3'h0;
		addr_out = 15'h0000;
		term_out = 1'b0;
	end

	// Reset pin level, clock-enable kept low
	task automatic reset_pin(input logic v, input int n);
		@(posedge clk_in);
		cke_out <= 1'b0;
		dev_resetn_out <= v;
		repeat (n) @(posedge clk_in);
		#1;
	endtask

	task automatic set_term(input logic v);
		@(posedge clk_in);
		term_out <= v;
		#1;
	endtask

	task automatic cmd(input logic [2:0] rcw, input logic [2:0] ba,
		input logic [14:0] a);
		@(posedge clk_in);
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} <= {1'b0, rcw};
		bank_out <= ba;
		addr_out <= a;
		@(posedge clk_in);
		{cs_n_out, ras_n_out, cas_n_out, we_n_out} <= 4'hf;
		// Deselected lines toggle rather than hold
		bank_out <= ~ba;
		addr_out <= ~a;
		#1;
	endtask

	task automatic mode(input logic [2:0] r, input logic [14:0] v);
		cmd(3'b000, r, v);
		repeat (MRD_CYC) @(posedge clk_in);
		#1;
	endtask

	task automatic start_cke();
		cmd(3'b111, 3'h0, 15'h0000);
		@(posedge clk_in);
		cke_out <= 1'b1;
		repeat (XPR_CYC) @(posedge clk_in);
		#1;
	endtask

	task automatic init_regs(input logic [14:0] m2, m3, m1, m0);
		mode(3'h2, m2);
		mode(3'h3, m3);
		mode(3'h1, m1);
		mode(3'h0, m0);
		cmd(3'b110, 3'h0, 15'h0400);
		repeat (LOCK_CYC) @(posedge clk_in);
		#1;
	endtask
endmodule

`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none

module tb;
	logic        clk_in = 1'b0;
	logic        resetn_in = 1'b0;
	logic        dres, cke, cs_n, ras_n, cas_n, we_n, term;
	logic [2:0]  ba, bbk;
	logic [14:0] ad, bcol;
	logic        ten, busy, dll, bst, bwr, bch, bap, hrdy, hresp;
	logic [23:0] ord;
	logic [7:0]  slv;
	logic [3:0]  wsd;
	logic        hsel = 1'b0, hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [2:0]  hsize = 3'h2;
	logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, r;
	int          err_total = 0;
	int          checks = 0;
	int          cyc = 0;

	always #2.5 clk_in = ~clk_in;

	sdm_ctl_model sdm_ctl_model_i (.clk_in(clk_in), .dev_resetn_out(dres),
		.cke_out(cke), .cs_n_out(cs_n), .ras_n_out(ras_n),
		.cas_n_out(cas_n), .we_n_out(we_n), .bank_out(ba),
		.addr_out(ad), .term_out(term));

	sdm_core sdm_core_i (.clk_in(clk_in), .resetn_in(resetn_in),
		.dev_resetn_in(dres), .cke_in(cke), .cs_n_in(cs_n),
		.ras_n_in(ras_n), .cas_n_in(cas_n), .we_n_in(we_n),
		.bank_select_lines_in(ba), .addr_in(ad),
		.termination_control_input_in(term),
		.termination_enable_out(ten), .init_busy_out(busy),
		.dll_reset_out(dll), .burst_start_out(bst),
		.burst_write_out(bwr), .burst_chop_out(bch),
		.auto_precharge_out(bap), .burst_bank_out(bbk),
		.burst_col_out(bcol), .burst_order_out(ord),
		.burst_slot_valid_out(slv), .write_start_delay_out(wsd),
		.hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans),
		.hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
		.hready_in(hrdy), .hrdata_out(hrdata),
		.hreadyout_out(hrdy), .hresp_out(hresp));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(posedge clk_in) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			$display("mismatch at %0t: timeout", $time);
			finish_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a,
		input logic [31:0] wd, output logic [31:0] rdat);
		@(posedge clk_in);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= sdm_pkg::HTRANS_NONSEQ;
		do @(posedge clk_in); while (hrdy !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_in); while (hrdy !== 1'b1);
		rdat = hrdata;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, {24'h000000, a}, 32'h0, d);
		chk(d, exp);
	endtask

	// Expected status word: banks, written mask, term, busy, state
	function automatic logic [31:0] stat(input logic [7:0] bk,
		input logic [3:0] m, input logic t, b, input logic [1:0] s);
		return {16'h0000, bk, m, t, b, s};
	endfunction

	function automatic logic [23:0] ord_exp(input logic [2:0] c,
		input logic il, input logic w);
		logic [23:0] o;
		logic [2:0]  i;
		o = 24'h000000;
		for (int k = 0; k < 8; k++) begin
			i = k[2:0];
			if (w) o[3*k +: 3] = i;
			else if (il) o[3*k +: 3] = c ^ i;
			else o[3*k +: 3] = {c[2] ^ i[2], c[1:0] + i[1:0]};
		end
		return o;
	endfunction

	// ==========================================================
	// Main sequence
	initial begin
		repeat (4) @(posedge clk_in);
		resetn_in <= 1'b1;
		sdm_ctl_model_i.set_term(1'b1);
		rd(sdm_pkg::OFS_STATUS, stat(8'h0, 4'h0, 1'b0, 1'b1, 2'h0));
		sdm_ctl_model_i.reset_pin(1'b1, 8);
		rd(sdm_pkg::OFS_STATUS, stat(8'h0, 4'h0, 1'b0, 1'b1, 2'h1));
		chk(32'(ten), 32'h0);
		chk(32'(busy), 32'h1);
		sdm_ctl_model_i.set_term(1'b0);
		for (int p = 0; p < 2; p++) begin
			sdm_ctl_model_i.start_cke();
			rd(sdm_pkg::OFS_STATUS, stat(8'h0, 4'h0, 1'b0, 1'b0, 2'h2));
			sdm_ctl_model_i.init_regs(15'h0018, 15'h0004, 15'h0006,
				15'h0120);
			rd(sdm_pkg::OFS_MODE2, 32'h18);
			rd(sdm_pkg::OFS_MODE3, 32'h4);
			rd(sdm_pkg::OFS_MODE1, 32'h6);
			rd(sdm_pkg::OFS_MODE0, 32'h20);
			rd(sdm_pkg::OFS_STATUS, stat(8'h0, 4'hf, 1'b0, 1'b0, 2'h2));
			if (p == 0) begin
				sdm_ctl_model_i.set_term(1'b1);
				rd(sdm_pkg::OFS_STATUS, stat(8'h0, 4'hf, 1'b1, 1'b0, 2'h2));
				sdm_ctl_model_i.reset_pin(1'b0, 20);
				chk(32'(ten), 32'h0);
				rd(sdm_pkg::OFS_STATUS, stat(8'h0, 4'h0, 1'b0, 1'b1, 2'h0));
				sdm_ctl_model_i.set_term(1'b0);
				sdm_ctl_model_i.reset_pin(1'b1, 8);
				sdm_ctl_model_i.cmd(3'b000, 3'h2, 15'h7fff);
				rd(sdm_pkg::OFS_MODE2, 32'h18);
			end
		end
		sdm_ctl_model_i.cmd(3'b000, 3'h0, 15'h0120);
		chk(32'(dll), 32'h1);
		// Mode-to-command spacing before the activates
		repeat (4) @(posedge clk_in);
		sdm_ctl_model_i.cmd(3'b011, 3'h3, 15'h0abc);
		sdm_ctl_model_i.cmd(3'b011, 3'h7, 15'h0001);
		rd(sdm_pkg::OFS_STATUS, stat(8'h88, 4'hf, 1'b0, 1'b0, 2'h2));
		for (int il = 0; il < 2; il++) begin
			sdm_ctl_model_i.cmd(3'b010, 3'h0, 15'h0400);
			sdm_ctl_model_i.mode(3'h0, {11'h004, il[0], 3'h0});
			sdm_ctl_model_i.cmd(3'b011, 3'h3, 15'h0abc);
			for (int c = 0; c < 8; c++) begin
				sdm_ctl_model_i.cmd(3'b101, 3'h3, {12'h200, c[2:0]});
				chk(32'(bst), 32'h1);
				chk(32'(ord), 32'(ord_exp(c[2:0], il[0], 1'b0)));
				chk(32'(slv), 32'hff);
				chk(32'(bcol), {17'h0, 12'h200, c[2:0]});
				if (c == 1)
					chk(32'(ord), il ? 32'h00de54c1 : 32'h009f50d1);
			end
		end
		sdm_ctl_model_i.cmd(3'b011, 3'h7, 15'h0001);
		@(posedge clk_in);
		#1;
		chk(32'(bst), 32'h0);
		sdm_ctl_model_i.cmd(3'b100, 3'h3, 15'h0405);
		chk({bwr, bap, bbk}, 32'h1b);
		chk(32'(ord), 32'(ord_exp(3'h5, 1'b1, 1'b1)));
		rd(sdm_pkg::OFS_STATUS, stat(8'h80, 4'hf, 1'b0, 1'b0, 2'h2));
		sdm_ctl_model_i.cmd(3'b010, 3'h0, 15'h0400);
		rd(sdm_pkg::OFS_STATUS, stat(8'h00, 4'hf, 1'b0, 1'b0, 2'h2));
		sdm_ctl_model_i.mode(3'h0, 15'h0021);
		sdm_ctl_model_i.cmd(3'b011, 3'h3, 15'h0abc);
		sdm_ctl_model_i.cmd(3'b101, 3'h3, 15'h0001);
		chk({bch, slv, ord[11:0]}, {11'h0, 9'h10f, 12'(ord_exp(3'h1, 1'b0, 1'b0))});
		chk(32'(wsd), 32'h5);
		sdm_ctl_model_i.cmd(3'b101, 3'h3, 15'h1001);
		chk({bch, slv}, 32'h0ff);
		sdm_ctl_model_i.cmd(3'b010, 3'h0, 15'h0400);
		sdm_ctl_model_i.mode(3'h0, 15'h0022);
		sdm_ctl_model_i.cmd(3'b011, 3'h3, 15'h0abc);
		sdm_ctl_model_i.cmd(3'b101, 3'h3, 15'h1006);
		chk({bch, slv}, 32'h10f);
		chk(32'(wsd), 32'h3);
		ahb(1'b1, {24'h0, sdm_pkg::OFS_CTRL}, 32'h7, r);
		rd(sdm_pkg::OFS_CTRL, 32'h7);
		// New base takes effect at the next access
		sdm_ctl_model_i.cmd(3'b101, 3'h3, 15'h1006);
		chk(32'(wsd), 32'h5);
		ahb(1'b1, {24'h0, sdm_pkg::OFS_MODE0}, 32'hffff, r);
		rd(sdm_pkg::OFS_MODE0, 32'h22);
		ahb(1'b0, 32'h00000100, 32'h0, r);
		chk(r, 32'h0);
		rd(8'h20, 32'h0);
		chk(32'(hresp), 32'h0);
		finish_test();
	end
endmodule

`default_nettype wire
